// ==== samux_defs.vh ====
// Contract
// - Chip select low for whole conversion
// - Start and address sampled on rising clock
// - Address three bits or four bits
// - First one is start; then select input
// - Half period later: convert, busy, ignore input
// - Decisions driven out on falling edges
// - Trial bit kept only if input higher
// - Eight periods; busy drops half later
// - Negative input above positive gives zero
// - Result held for LSB-first readout
// - Shift enable high holds LSB out (four-input variant ignores shift enable)
// - After eight LSB bits, output low
// - Chip select high floats data and busy
// - Deselect clears all; new start needed
// - Four-input differential pair and polarity
// - Four-input single-ended channel, ground negative
// - Eight-input single-ended uses common input
`ifndef SAMUX_DEFS_VH
`define SAMUX_DEFS_VH
`define SAMUX_RES_BITS 8
`define SAMUX_ADDR_BITS_4 3
`define SAMUX_ADDR_BITS_8 4
`define SAMUX_CNT_W 4
`define SAMUX_CH_COM 4'hF
`define SAMUX_CH_GND 4'hE
`endif

// ==== samux_sync.v ====
`timescale 1ns/1ps
// Two-stage synchroniser, one per bit
module samux_sync #(
  parameter WIDTH = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta; // First stage, read only by second
  // Two flops per bit
  always @(posedge mclk) begin
    if (sys_rst) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== samux_seq.v ====
`timescale 1ns/1ps
`include "samux_defs.vh"
// Serial ADC sequencer; link clock sampled by mclk
module samux_seq #(
  parameter EIGHT_INPUT = 1
) (
  input wire mclk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire serial_clk,
  input wire serial_data_in,
  input wire lsb_shift_enable_n,
  input wire input_above_dac,
  output reg [`SAMUX_RES_BITS-1:0] dac_code,
  output reg [3:0] pos_channel,
  output reg [3:0] neg_channel,
  output reg mux_valid,
  output reg serial_data_out,
  output reg serial_data_out_oe,
  output reg conversion_busy,
  output reg conversion_busy_oe
);
  // Address length depends on variant
  localparam ABITS = EIGHT_INPUT ? `SAMUX_ADDR_BITS_8 : `SAMUX_ADDR_BITS_4;
  localparam [`SAMUX_CNT_W-1:0] LAST_BIT = `SAMUX_RES_BITS - 1;
  // Count of the final address bit, sized to the counter
  localparam [`SAMUX_CNT_W-1:0] ADDR_LAST = ABITS - 1;
  // First trial code: only the MSB set
  localparam [`SAMUX_RES_BITS-1:0] MSB_ONE = {1'b1, {(`SAMUX_RES_BITS-1){1'b0}}};
  // States
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_SETTLE = 3'd2;
  localparam [2:0] ST_CONV = 3'd3;
  localparam [2:0] ST_TAIL = 3'd4;
  localparam [2:0] ST_LSB = 3'd5;
  localparam [2:0] ST_DONE = 3'd6;

  wire [3:0] sync_bus; // Synchronised pins
  wire cs_n_s;
  wire clk_s;
  wire din_s;
  wire se_n_s;
  reg clk_d; // Previous link clock level
  reg [2:0] state;
  reg [`SAMUX_CNT_W-1:0] bit_cnt; // Bit counter
  reg [3:0] addr; // Address shift register
  reg [`SAMUX_RES_BITS-1:0] result; // Output shift register
  wire rise;
  wire fall;
  reg [3:0] next_pos; // Decoded positive input
  reg [3:0] next_neg; // Decoded negative input
  reg [`SAMUX_RES_BITS-1:0] trial_mask; // One-hot bit under trial
  reg [`SAMUX_RES_BITS-1:0] next_mask; // One-hot bit tried next, zero after LSB
  reg [`SAMUX_RES_BITS-1:0] kept_code; // Code once this decision is applied

  samux_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({chip_select_n, serial_clk, serial_data_in, lsb_shift_enable_n}),
    .sync_out(sync_bus)
  );
  assign cs_n_s = sync_bus[3];
  assign clk_s = sync_bus[2];
  assign din_s = sync_bus[1];
  assign se_n_s = sync_bus[0];

  // Edges found from sampled clock; works gated or free running
  assign rise = clk_s & ~clk_d;
  assign fall = ~clk_s & clk_d;

  // Edge history
  always @(posedge mclk) begin
    if (sys_rst) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= clk_s;
    end
  end

  // Channel decode from the captured address
  // Channel code is {select bits, polarity}; the pair partner differs in bit 0
  always @* begin
    next_pos = `SAMUX_CH_GND;
    next_neg = `SAMUX_CH_GND;
    if (EIGHT_INPUT) begin
      // Eight inputs: mode, polarity, select[1:0]
      next_pos = {1'b0, addr[1:0], addr[2]};
      if (addr[3]) begin
        // Single-ended against the common input
        next_neg = `SAMUX_CH_COM;
      end else begin
        // Adjacent pair; polarity picks the positive side
        next_neg = {1'b0, addr[1:0], ~addr[2]};
      end
    end else begin
      // Four inputs: mode, polarity, select
      next_pos = {2'b00, addr[0], addr[1]};
      if (addr[2]) begin
        // Single-ended against ground
        next_neg = `SAMUX_CH_GND;
      end else begin
        // Adjacent pair; polarity picks the positive side
        next_neg = {2'b00, addr[0], ~addr[1]};
      end
    end
  end

  // One SAR step: drop the trial bit on a low decision, then try the next
  // Past the LSB the next mask is zero, so the last step only keeps or drops
  always @* begin
    trial_mask = MSB_ONE >> bit_cnt;
    next_mask = trial_mask >> 1;
    if (input_above_dac) begin
      // Input above the trial level: keep the bit
      kept_code = dac_code;
    end else begin
      // Not above: remove it; a reversed input never keeps any bit
      kept_code = dac_code & ~trial_mask;
    end
  end

  // Main sequencer
  always @(posedge mclk) begin
    if (sys_rst || cs_n_s) begin
      // Deselect clears everything, outputs float
      state <= ST_IDLE;
      bit_cnt <= {`SAMUX_CNT_W{1'b0}};
      addr <= 4'h0;
      result <= {`SAMUX_RES_BITS{1'b0}};
      dac_code <= {`SAMUX_RES_BITS{1'b0}};
      pos_channel <= `SAMUX_CH_GND;
      neg_channel <= `SAMUX_CH_GND;
      mux_valid <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_out_oe <= 1'b0;
      conversion_busy <= 1'b0;
      conversion_busy_oe <= 1'b0;
    end else begin
      // Busy line driven while selected
      conversion_busy_oe <= 1'b1;
      case (state)
        ST_IDLE: begin
          // Wait for first sampled one
          if (rise && din_s) begin
            state <= ST_ADDR;
            bit_cnt <= {`SAMUX_CNT_W{1'b0}};
          end
        end
        ST_ADDR: begin
          // Shift address bits: mode, polarity, select MSB first
          if (rise) begin
            addr <= {addr[2:0], din_s};
            if (bit_cnt == ADDR_LAST) begin
              state <= ST_SETTLE;
            end else begin
              bit_cnt <= bit_cnt + 4'd1;
            end
          end
        end
        ST_SETTLE: begin
          // Inputs selected; conversion waits for next falling edge
          mux_valid <= 1'b1;
          pos_channel <= next_pos;
          neg_channel <= next_neg;
          if (fall) begin
            // Half period after selection; input now ignored
            state <= ST_CONV;
            conversion_busy <= 1'b1;
            bit_cnt <= {`SAMUX_CNT_W{1'b0}};
            dac_code <= MSB_ONE;
          end
        end
        ST_CONV: begin
          // Comparator strobed at end of period, bit out on fall
          if (fall) begin
            // Keep or drop this bit and raise the next trial in one step
            dac_code <= kept_code | next_mask;
            result <= {result[`SAMUX_RES_BITS-2:0], input_above_dac};
            serial_data_out <= input_above_dac;
            serial_data_out_oe <= 1'b1;
            if (bit_cnt == LAST_BIT) begin
              state <= ST_TAIL;
              bit_cnt <= {`SAMUX_CNT_W{1'b0}};
            end else begin
              bit_cnt <= bit_cnt + 4'd1;
            end
          end
        end
        ST_TAIL: begin
          // Busy falls half a period after the last decision
          if (rise) begin
            conversion_busy <= 1'b0;
            state <= ST_LSB;
          end
        end
        ST_LSB: begin
          // LSB stays out while shift enable high (always low on 4-input)
          if (fall && (!EIGHT_INPUT || !se_n_s)) begin
            if (bit_cnt == LAST_BIT) begin
              serial_data_out <= 1'b0;
              state <= ST_DONE;
            end else begin
              serial_data_out <= result[1];
              result <= {1'b0, result[`SAMUX_RES_BITS-1:1]};
              bit_cnt <= bit_cnt + 4'd1;
            end
          end
        end
        ST_DONE: begin
          // Low until deselect
          serial_data_out <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== samux_monitor.sv ====
`timescale 1ns/1ps
// Pin watcher; sync stages add 2 mclk
module samux_mon (
  input wire mclk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire mux_valid,
  input wire serial_data_out_oe,
  input wire conversion_busy,
  input wire conversion_busy_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int n; // Busy length in mclk
  always @(posedge mclk) n <= conversion_busy ? n + 1 : 0;
  a_float_idle: assert property (chip_select_n [*4] |->
    !serial_data_out_oe && !conversion_busy_oe) else $error("driven");
  a_clear_idle: assert property (chip_select_n [*4] |->
    !mux_valid && !conversion_busy) else $error("not clear");
  a_mux_first: assert property ($rose(conversion_busy) |->
    $past(mux_valid, 3)) else $error("early busy");
  a_settle_gap: assert property ($rose(mux_valid) |->
    !conversion_busy [*3]) else $error("no settle");
  a_busy_span: assert property ($fell(conversion_busy) && !chip_select_n |->
    n inside {[66:70]}) else $error("busy span");
  a_msb_out: assert property ($rose(conversion_busy) |->
    ##[7:9] serial_data_out_oe) else $error("no msb");
  a_float_early: assert property ($rose(serial_data_out_oe) |->
    conversion_busy) else $error("early data");
  a_busy_pin: assert property (conversion_busy |->
    conversion_busy_oe) else $error("busy float");
endmodule
bind samux_seq samux_mon i_mon (.*);

// ==== samux_host.sv ====
`timescale 1ns/1ps
// Host end; its clock stands still between frames
module samux_host (
  input wire mclk,
  input wire line_in,
  output reg chip_select_n = 1'b1,
  output reg serial_clk = 1'b0,
  output reg serial_data_in = 1'b0,
  output reg lsb_shift_enable_n = 1'b1
);
  reg [16:0] s; // Line seen just before each fall
  // One link period of 8 mclk; clock idles low outside frames
  task cyc;
    repeat (4) @(posedge mclk);
    serial_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    s = {s[15:0], line_in};
    serial_clk <= 1'b0;
  endtask
  // Fresh select, idle zero, start, address, then junk
  task frame(input [5:0] cmd, input [15:0] junk);
    integer i;
    chip_select_n <= 1'b1;
    lsb_shift_enable_n <= 1'b1;
    repeat (12) @(posedge mclk);
    chip_select_n <= 1'b0;
    for (i = 0; i < 23; i = i + 1) begin
      serial_data_in <= i < 6 ? cmd[5 - i] : junk[i[3:0]];
      if (i == 14) lsb_shift_enable_n <= 1'b0;
      cyc;
    end
  endtask
endmodule

// ==== samux_tb.sv ====
`timescale 1ns/1ps
module tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] vin = 8'h00, v;
  reg [3:0] a;
  reg [31:0] seed = 32'h0001573D;
  integer fails = 0, n_tests = 0, k;
  wire chip_select_n, serial_clk, serial_data_in, lsb_shift_enable_n;
  wire serial_data_out, serial_data_out_oe, mux_valid;
  wire conversion_busy, conversion_busy_oe;
  wire [7:0] dac_code;
  wire [3:0] pos_channel, neg_channel;
  wire [7:0] dac_code4;
  wire [3:0] pos_channel4, neg_channel4;
  wire input_above_dac = vin > dac_code;
  wire input_above_dac4 = vin > dac_code4;
  // Floating line reads as its inverse
  wire line_in = serial_data_out_oe ? serial_data_out : ~serial_data_out;
  always #25 mclk = ~mclk;
  samux_seq i_dut (.*);
  samux_host i_host (.*);
  // Four-input variant on the same pins; only its decode is compared
  samux_seq #(.EIGHT_INPUT(0)) i_dut4 (.mclk(mclk), .sys_rst(sys_rst),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .lsb_shift_enable_n(lsb_shift_enable_n),
    .input_above_dac(input_above_dac4), .dac_code(dac_code4),
    .pos_channel(pos_channel4), .neg_channel(neg_channel4), .mux_valid(),
    .serial_data_out(), .serial_data_out_oe(), .conversion_busy(),
    .conversion_busy_oe());
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // Float (inverse of cleared low), MSB first, shared LSB, bits 1..7, low
  function [16:0] ex(input [7:0] x);
    integer i;
    reg [7:0] r;
    r = x == 8'h00 ? 8'h00 : x - 8'h01;
    ex = {1'b1, r, 8'h00};
    for (i = 1; i < 8; i = i + 1) ex[8 - i] = r[i];
  endfunction
  task chk(input string nm, input [16:0] e, input [16:0] s);
    n_tests = n_tests + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task print_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 0; k < 20; k = k + 1) begin
      seed = xs(seed);
      v = k == 16 ? 8'h00 : k == 17 ? 8'hFF : seed[7:0];
      a = k < 16 ? k[3:0] : seed[11:8];
      vin <= v;
      i_host.frame({2'b01, a}, seed[31:16]);
      chk("stream", ex(v), i_host.s);
      chk("mux", {10'h000, a[1:0], a[2], a[3] ? 4'hF : {1'b0, a[1:0], ~a[2]}},
        {9'h000, pos_channel, neg_channel});
      chk("mux4", {11'h000, a[1], a[2], a[3] ? 4'hE : {2'b00, a[1], ~a[2]}},
        {9'h000, pos_channel4, neg_channel4});
      $display("test %0d done", k);
    end
    print_verdict;
  end
endmodule
